/* File: rtl/orl_pkg.sv */
package orl_pkg;
    localparam int NUM_RELAYS = 5;
    localparam int NUM_ASSIGN = 7;
    localparam int SIG_W      = 16;
    localparam int SEL_W      = 4;
    localparam int HOLD_W     = 15;
    localparam int ADDR_W     = 6;
    localparam int TICK_W     = 17;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FORCE      = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_RELAY_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_RELAY_END  = 6'h38;

    // Control register fields
    localparam int CTRL_DISARM_EN  = 0;
    localparam int CTRL_DISARM_CMD = 1;
    localparam int CTRL_GFORCE_LSB = 2;
    localparam int CTRL_EXTSEL_LSB = 4;
    localparam int CTRL_SCADA_ACK  = 8;

    // Per relay configuration fields
    localparam int CFG_INV_LSB   = 0;
    localparam int CFG_COLL_INV  = 7;
    localparam int CFG_LATCH     = 8;
    localparam int CFG_ACKSEL_LSB = 9;
    localparam int CFG_ZONE      = 13;
    localparam int CFG_HOLD_LSB  = 14;

    // Status fields
    localparam int ST_OUT_LSB    = 0;
    localparam int ST_LATCH_LSB  = 5;
    localparam int ST_DISARM_LSB = 10;
    localparam int ST_LIFE       = 15;
    localparam int ST_BOOTED     = 16;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Hold time counts in steps of 10 ms
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned TICK_PERIOD_NS = 10_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        FORCE_NORMAL = 2'h0,
        FORCE_OFF    = 2'h1,
        FORCE_ON     = 2'h2
    } orl_force_type;

    typedef enum logic [1:0] {
        LIFE_BOOT  = 2'h0,
        LIFE_RUN   = 2'h1,
        LIFE_FAULT = 2'h3
    } orl_life_type;
endpackage : orl_pkg

/* File: rtl/orl_relay_ctrl.sv */
// Behaviour
// - Latched relay states are reloaded from retained storage after power returns.
// - Latched state survives any reconfiguration, even clearing the latch setting.
// - Only an acknowledge event releases a latched relay.
// - Life contact has no settings: no assignment, inversion or latching.
// - Panel clear button press acknowledges latched relays.
// - Each relay has its own selectable acknowledge, effective only when latching.
// - Rising selected external acknowledge signal acknowledges all relays at once.
// - Supervisory acknowledge command acknowledges all relays at once.
// - Life contact energized only while no internal fault is present.
// - Life contact stays off for the whole boot sequence.
// - Successful startup energizes life contact and lights its LED.
// - Disarm command works only after disarm enable is set; both default off.
// - Disarm skips relays that are latched or in a running hold time.
// - Zone interlock relays and the life contact are never disarmed.
// - Each relay has a normal, forced off or forced on setting, default normal.
// - Group force overrides each relay force whenever not normal.
// - Acknowledge accepted only once set signals are gone and hold time elapsed.
// - Relay state is OR of up to 7 invertible signals, result invertible.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module orl_relay_ctrl import orl_pkg::*; #(
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic [ADDR_W-1:0]     avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic [SIG_W-1:0]      sigIn,
    input  wire logic                  panelClearBtn,
    input  wire logic                  internalFault,
    input  wire logic                  startupDone,
    input  wire logic [NUM_RELAYS-1:0] nvLatchIn,
    output logic      [NUM_RELAYS-1:0] nvLatchOut,
    output logic      [NUM_RELAYS-1:0] relayOut,
    output logic                       lifeContact,
    output logic                       lifeLed
);
    typedef struct packed {
        logic                                  busAck;
        logic [31:0]                           rdata;
        logic                                  disarmEn;
        logic                                  disarmCmd;
        logic [1:0]                            groupForce;
        logic [SEL_W-1:0]                      extSel;
        logic [NUM_RELAYS-1:0][1:0]            relayForce;
        logic [NUM_RELAYS-1:0][27:0]           sel;
        logic [NUM_RELAYS-1:0][28:0]           cfg;
        logic [NUM_RELAYS-1:0]                 normState;
        logic [NUM_RELAYS-1:0][HOLD_W-1:0]     holdCnt;
        logic [NUM_RELAYS-1:0]                 latched;
        logic [NUM_RELAYS-1:0]                 disarmed;
        logic [NUM_RELAYS-1:0]                 out;
        orl_life_type                          lifeState;
        logic                                  life;
        logic                                  loaded;
    } orl_state_type;

    orl_state_type             st;
    orl_state_type             next_st;
    logic [SIG_W-1:0]          sigLevel;
    logic [SIG_W-1:0]          sigRise;
    logic                      panelRise;
    logic                      tick;
    logic [NUM_RELAYS-1:0]     ackVec;
    logic [NUM_RELAYS-1:0]     zoneMask;

    // Digital inputs and panel button are asynchronous pins
    orl_sync_edge #(.W(SIG_W)) u_sigSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn (sigIn),
        .level   (sigLevel),
        .rise    (sigRise)
    );

    orl_sync_edge #(.W(1)) u_panelSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn (panelClearBtn),
        .level   (),
        .rise    (panelRise)
    );

    orl_tick_gen #(.CYCLES(TICK_CYC)) u_tick (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .tick    (tick)
    );

    function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : mergeBe

    function automatic logic isRelay(input logic [ADDR_W-1:0] a);
        return (a >= OFS_RELAY_BASE) && (a < OFS_RELAY_END) && (a[1:0] == 2'h0);
    endfunction : isRelay

    function automatic logic [2:0] relayIdx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFS_RELAY_BASE;
        return d[5:3];
    endfunction : relayIdx

    // Selector 0 means unassigned; unassigned slots add nothing to the OR
    function automatic logic assignOr(input logic [27:0] s, input logic [6:0] inv,
                                      input logic [SIG_W-1:0] lv);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_ASSIGN; k++) begin
            if (s[k*SEL_W +: SEL_W] != '0) begin
                r = r | (lv[s[k*SEL_W +: SEL_W]] ^ inv[k]);
            end
        end
        return r;
    endfunction : assignOr

    always_comb begin
        logic [31:0]       rd;
        logic [31:0]       wv;
        logic              doWrite;
        logic              scadaAck;
        logic              extRise;
        logic              disarmEvt;
        logic              want;
        logic              busy;
        logic              latchEn;
        logic [1:0]        f;
        logic [2:0]        ri;
        logic [HOLD_W-1:0] holdSet;
        rd        = REG_RESET;
        wv        = REG_RESET;
        doWrite   = 1'b0;
        scadaAck  = 1'b0;
        extRise   = 1'b0;
        disarmEvt = 1'b0;
        want      = 1'b0;
        busy      = 1'b0;
        latchEn   = 1'b0;
        f         = FORCE_NORMAL;
        ri        = '0;
        holdSet   = '0;
        ackVec    = '0;
        zoneMask  = '0;
        next_st   = st;

        // One wait state per access: request seen, then answered
        next_st.busAck = (avs_read || avs_write) && !st.busAck;
        if (next_st.busAck) begin
            if (avs_address == OFS_CTRL) begin
                rd[CTRL_DISARM_EN]                = st.disarmEn;
                rd[CTRL_DISARM_CMD]               = st.disarmCmd;
                rd[CTRL_GFORCE_LSB +: 2]          = st.groupForce;
                rd[CTRL_EXTSEL_LSB +: SEL_W]      = st.extSel;
            end else if (avs_address == OFS_FORCE) begin
                rd[2*NUM_RELAYS-1:0] = st.relayForce;
            end else if (avs_address == OFS_STATUS) begin
                rd[ST_OUT_LSB +: NUM_RELAYS]    = st.out;
                rd[ST_LATCH_LSB +: NUM_RELAYS]  = st.latched;
                rd[ST_DISARM_LSB +: NUM_RELAYS] = st.disarmed;
                rd[ST_LIFE]                     = st.life;
                rd[ST_BOOTED]                   = st.lifeState != LIFE_BOOT;
            end else if (isRelay(avs_address)) begin
                ri = relayIdx(avs_address);
                if (avs_address[2]) begin
                    rd[28:0] = st.cfg[ri];
                end else begin
                    rd[27:0] = st.sel[ri];
                end
            end
            next_st.rdata = rd;
        end

        // Writes land on the edge where waitrequest is low
        doWrite = st.busAck && avs_write;
        if (doWrite) begin
            if (avs_address == OFS_CTRL) begin
                wv = mergeBe({23'h0, 1'b0, st.extSel, st.groupForce, st.disarmCmd, st.disarmEn},
                             avs_writedata, avs_byteenable);
                next_st.disarmEn   = wv[CTRL_DISARM_EN];
                next_st.disarmCmd  = wv[CTRL_DISARM_CMD] && st.disarmEn;
                next_st.groupForce = wv[CTRL_GFORCE_LSB +: 2];
                next_st.extSel     = wv[CTRL_EXTSEL_LSB +: SEL_W];
                scadaAck           = wv[CTRL_SCADA_ACK];
                disarmEvt          = next_st.disarmCmd && !st.disarmCmd;
            end else if (avs_address == OFS_FORCE) begin
                wv = mergeBe({22'h0, st.relayForce}, avs_writedata, avs_byteenable);
                next_st.relayForce = wv[2*NUM_RELAYS-1:0];
            end else if (isRelay(avs_address)) begin
                ri = relayIdx(avs_address);
                if (avs_address[2]) begin
                    wv = mergeBe({3'h0, st.cfg[ri]}, avs_writedata, avs_byteenable);
                    next_st.cfg[ri] = wv[28:0];
                end else begin
                    wv = mergeBe({4'h0, st.sel[ri]}, avs_writedata, avs_byteenable);
                    next_st.sel[ri] = wv[27:0];
                end
            end
        end

        extRise = (st.extSel != '0) && sigRise[st.extSel];

        for (int i = 0; i < NUM_RELAYS; i++) begin
            latchEn = st.cfg[i][CFG_LATCH];
            holdSet = st.cfg[i][CFG_HOLD_LSB +: HOLD_W];
            want    = assignOr(st.sel[i], st.cfg[i][CFG_INV_LSB +: NUM_ASSIGN], sigLevel)
                      ^ st.cfg[i][CFG_COLL_INV];
            busy    = st.holdCnt[i] != '0;
            zoneMask[i] = st.cfg[i][CFG_ZONE];

            // Each change of state is held for at least the hold time
            if (busy && tick) begin
                next_st.holdCnt[i] = st.holdCnt[i] - HOLD_W'(1);
            end
            if (!busy && (want != st.normState[i])) begin
                next_st.normState[i] = want;
                next_st.holdCnt[i]   = holdSet;
            end

            ackVec[i] = panelRise || extRise || scadaAck
                        || (latchEn && st.cfg[i][CFG_ACKSEL_LSB +: SEL_W] != '0
                            && sigRise[st.cfg[i][CFG_ACKSEL_LSB +: SEL_W]]);

            // Clear needs an ack with sources gone and hold expired; a set wins
            if (!st.loaded) begin
                next_st.latched[i] = nvLatchIn[i];
            end else begin
                if (ackVec[i] && !want && !st.normState[i] && !busy) begin
                    next_st.latched[i] = 1'b0;
                end
                if (latchEn && next_st.normState[i]) begin
                    next_st.latched[i] = 1'b1;
                end
            end

            if (disarmEvt && !st.latched[i] && !busy && !st.cfg[i][CFG_ZONE]) begin
                next_st.disarmed[i] = 1'b1;
            end
            // Dropping the command or the enable re-arms every relay
            if (!next_st.disarmEn || !next_st.disarmCmd) begin
                next_st.disarmed[i] = 1'b0;
            end

            f = (next_st.groupForce != FORCE_NORMAL) ? next_st.groupForce
                                                     : next_st.relayForce[i];
            if (f == FORCE_ON) begin
                next_st.out[i] = 1'b1;
            end else if (f == FORCE_OFF) begin
                next_st.out[i] = 1'b0;
            end else begin
                next_st.out[i] = !next_st.disarmed[i]
                                 && (next_st.latched[i] || next_st.normState[i]);
            end
        end
        next_st.loaded = 1'b1;

        // Life contact depends only on health and boot, never on settings
        case (st.lifeState)
            LIFE_BOOT: begin
                if (startupDone && !internalFault) begin
                    next_st.lifeState = LIFE_RUN;
                end
            end
            LIFE_RUN: begin
                if (internalFault) begin
                    next_st.lifeState = LIFE_FAULT;
                end
            end
            LIFE_FAULT: begin
                if (!internalFault) begin
                    next_st.lifeState = LIFE_RUN;
                end
            end
            default: begin
                next_st.lifeState = LIFE_BOOT;
            end
        endcase
        next_st.life = (next_st.lifeState == LIFE_RUN);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign avs_waitrequest = !st.busAck;
    assign avs_readdata    = st.rdata;
    assign relayOut        = st.out;
    assign nvLatchOut      = st.latched;
    assign lifeContact     = st.life;
    assign lifeLed         = st.life;

    sequence seq_restore;
        !st.loaded ##1 st.loaded;
    endsequence

    sequence seq_boot_ok;
        st.lifeState == LIFE_BOOT && startupDone && !internalFault;
    endsequence

    chk_latch_restore: assert property (@(posedge clk_sys) disable iff (!nrst)
        seq_restore |-> st.latched == $past(nvLatchIn))
        else $error("latched state not restored from storage");

    chk_latch_release: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(st.loaded) && |($past(st.latched) & ~st.latched) |-> |$past(ackVec))
        else $error("latch released without acknowledge");

    chk_life_boot: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.lifeState == LIFE_BOOT |-> !lifeContact)
        else $error("life contact on during boot");

    chk_life_fault: assert property (@(posedge clk_sys) disable iff (!nrst)
        internalFault |=> !lifeContact)
        else $error("life contact on with fault");

    chk_life_start: assert property (@(posedge clk_sys) disable iff (!nrst)
        seq_boot_ok |=> lifeContact && lifeLed)
        else $error("life contact not energized after startup");

    chk_disarm_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
        |(st.disarmed & ~$past(st.disarmed)) |-> $past(st.disarmEn))
        else $error("disarm without enable");

    chk_disarm_latched: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(|(st.disarmed & ~$past(st.disarmed) & $past(st.latched))))
        else $error("latched relay disarmed");

    chk_zone_armed: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(|(st.disarmed & ~$past(st.disarmed) & $past(zoneMask))))
        else $error("zone interlock relay disarmed");

    chk_group_force: assert property (@(posedge clk_sys) disable iff (!nrst)
        ##1 st.groupForce == FORCE_ON && $past(st.groupForce) == FORCE_ON |-> &relayOut)
        else $error("group force on not applied");

    chk_bus_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer later than one wait state");
endmodule : orl_relay_ctrl
`default_nettype wire

/* File: rtl/orl_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module orl_sync_edge import orl_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } orl_sync_type;

    orl_sync_type st;
    orl_sync_type next_st;

    // Only s2 may look at s1
    always_comb begin
        next_st      = st;
        next_st.s1   = asyncIn;
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.s2;
    assign rise  = st.s2 & ~st.prev;
endmodule : orl_sync_edge
`default_nettype wire

/* File: rtl/orl_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module orl_tick_gen import orl_pkg::*; #(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    output logic      tick
);
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic              tick;
    } orl_tick_type;

    orl_tick_type st;
    orl_tick_type next_st;

    always_comb begin
        next_st = st;
        if (st.cnt >= TICK_W'(CYCLES - 1)) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt  = st.cnt + TICK_W'(1);
            next_st.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : orl_tick_gen
`default_nettype wire

/* File: testbench/orl_plant_model.sv */
`timescale 1ns/1ps
`default_nettype none
module orl_plant_model import orl_pkg::*; (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic [NUM_RELAYS-1:0] relayOut,
    input  wire logic [NUM_RELAYS-1:0] nvLatchOut,
    output var  logic [NUM_RELAYS-1:0] nvLatchIn,
    output var  logic [NUM_RELAYS-1:0] contactClosed
);
    logic [NUM_RELAYS-1:0] retained;

    initial retained = '0;
    // Storage freezes while reset is low, so a supply break keeps the last latch image
    always @(posedge clk_sys) begin
        if (nrst) begin
            retained <= nvLatchOut;
        end
    end
    assign nvLatchIn     = retained;
    assign contactClosed = relayOut;
endmodule : orl_plant_model
`default_nettype wire

/* File: testbench/orl_relay_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module orl_relay_ctrl_tb_top import orl_pkg::*; ;
    logic                  clk_sys;
    logic                  nrst;
    logic [ADDR_W-1:0]     avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [3:0]            avs_byteenable;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic [SIG_W-1:0]      sigIn;
    logic                  panelClearBtn;
    logic                  internalFault;
    logic                  startupDone;
    logic [NUM_RELAYS-1:0] nvLatchIn;
    logic [NUM_RELAYS-1:0] nvLatchOut;
    logic [NUM_RELAYS-1:0] relayOut;
    logic                  lifeContact;
    logic                  lifeLed;
    logic [31:0]           st;
    int                    err_count;
    int                    comparisons;

    orl_relay_ctrl #(.TICK_CYC(4)) dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sigIn(sigIn),
        .panelClearBtn(panelClearBtn), .internalFault(internalFault), .startupDone(startupDone),
        .nvLatchIn(nvLatchIn), .nvLatchOut(nvLatchOut), .relayOut(relayOut), .lifeContact(lifeContact),
        .lifeLed(lifeLed));
    orl_plant_model plant (.clk_sys(clk_sys), .nrst(nrst), .relayOut(relayOut), .nvLatchOut(nvLatchOut),
        .nvLatchIn(nvLatchIn), .contactClosed());

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    task automatic complete_run();
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Answer is taken from the values that stood at the edge where waitrequest was low
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        logic w;
        int   n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk_sys);
            w = avs_waitrequest;
            n++;
        end while (w !== 1'b0 && n < 50);
        q = avs_readdata;
        if (w !== 1'b0) chk("waitrequest", 32'h0, 32'h1);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask : settle

    task automatic pulse(input logic [SIG_W-1:0] m);
        sigIn <= sigIn | m;
        settle();
        sigIn <= sigIn & ~m;
        settle();
    endtask : pulse

    task automatic press();
        panelClearBtn <= 1'b1;
        settle();
        panelClearBtn <= 1'b0;
        settle();
    endtask : press

    initial begin
        #2_000_000;
        err_count++;
        complete_run();
    end

    initial begin
        err_count = 0;
        comparisons = 0;
        nrst = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        sigIn = '0;
        panelClearBtn = 1'b0;
        internalFault = 1'b0;
        startupDone = 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_CTRL, st);
        chk("ctrl reset", 32'h0, st);
        avs_byteenable <= 4'h2;
        wr(OFS_CTRL, 32'hFF);
        avs_byteenable <= 4'hF;
        rd(OFS_CTRL, st);
        chk("byte lanes", 32'h0, st);
        rd(OFS_FORCE, st);
        chk("force reset", 32'h0, st);
        rd(6'h3C, st);
        chk("unmapped", 32'h0, st);
        wr(6'h3C, 32'hFFFF_FFFF);
        settle();
        chk("life boot", 32'h0, {30'h0, lifeContact, lifeLed});
        startupDone <= 1'b1;
        settle();
        chk("life run", 32'h3, {30'h0, lifeContact, lifeLed});
        internalFault <= 1'b1;
        settle();
        chk("life fault", 32'h0, {31'h0, lifeContact});
        internalFault <= 1'b0;
        settle();
        // Relay i watches sigIn[i+1]; 0..2 latch, 0 acks on sigIn[9], 3 is zone interlock
        for (int i = 0; i < NUM_RELAYS; i++) begin
            wr(OFS_RELAY_BASE + 6'(8 * i), 32'(i + 1));
            wr(OFS_RELAY_BASE + 6'(8 * i + 4), i == 0 ? 32'h1300 : i < 3 ? 32'h100 : i == 3 ? 32'h2000 : 32'h0);
        end
        pulse(16'h000E);
        rd(OFS_STATUS, st);
        chk("latch set", 32'hE7, {22'h0, st[9:0]});
        wr(OFS_RELAY_BASE + 6'h4, 32'h0);
        settle();
        chk("latch kept", 32'h1, {31'h0, relayOut[0]});
        sigIn <= 16'h0004;
        settle();
        press();
        rd(OFS_STATUS, st);
        chk("ack while set", 32'h1, {31'h0, st[6]});
        sigIn <= 16'h0000;
        settle();
        press();
        rd(OFS_STATUS, st);
        chk("panel ack", 32'h0, {22'h0, st[9:0]});
        wr(OFS_RELAY_BASE + 6'h4, 32'h1300);
        pulse(16'h0006);
        pulse(16'h0200);
        rd(OFS_STATUS, st);
        chk("own ack", 32'h2, {27'h0, st[9:5]});
        pulse(16'h0002);
        wr(OFS_CTRL, 32'h80);
        pulse(16'h0100);
        rd(OFS_STATUS, st);
        chk("external ack", 32'h0, {27'h0, st[9:5]});
        pulse(16'h0006);
        wr(OFS_CTRL, 32'h100);
        settle();
        rd(OFS_STATUS, st);
        chk("supervisory ack", 32'h0, {27'h0, st[9:5]});
        // Relay 2 latches with a hold of ten ticks; ack is refused until the hold has run out
        wr(OFS_RELAY_BASE + 6'h14, 32'h0002_8100);
        pulse(16'h0008);
        press();
        rd(OFS_STATUS, st);
        chk("ack in hold", 32'h1, {31'h0, st[7]});
        repeat (100) @(posedge clk_sys);
        press();
        rd(OFS_STATUS, st);
        chk("ack after hold", 32'h0, {31'h0, st[7]});
        pulse(16'h0002);
        wr(OFS_CTRL, 32'h2);
        rd(OFS_STATUS, st);
        chk("disarm no enable", 32'h0, {27'h0, st[14:10]});
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h3);
        sigIn <= 16'h0030;
        settle();
        rd(OFS_STATUS, st);
        chk("disarm set", 32'h16, {27'h0, st[14:10]});
        chk("disarm outs", 32'h09, {27'h0, relayOut});
        wr(OFS_CTRL, 32'h0);
        settle();
        chk("rearm", 32'h19, {27'h0, relayOut});
        wr(OFS_FORCE, 32'h9);
        settle();
        chk("relay force", 32'h1A, {27'h0, relayOut});
        wr(OFS_CTRL, 32'h8);
        settle();
        chk("group on", 32'h1F, {27'h0, relayOut});
        wr(OFS_CTRL, 32'h4);
        settle();
        chk("group off", 32'h0, {27'h0, relayOut});
        wr(OFS_CTRL, 32'h0);
        wr(OFS_FORCE, 32'h0);
        wr(OFS_RELAY_BASE + 6'h24, 32'h01);
        settle();
        chk("signal invert", 32'h0, {31'h0, relayOut[4]});
        wr(OFS_RELAY_BASE + 6'h24, 32'h81);
        settle();
        chk("result invert", 32'h1, {31'h0, relayOut[4]});
        nrst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        settle();
        rd(OFS_STATUS, st);
        chk("latch restored", 32'h21, {22'h0, st[9:0]});
        complete_run();
    end
endmodule : orl_relay_ctrl_tb_top
`default_nettype wire
